// ### shared/ccr_map.svh
// Register offsets, field positions, reset values and write masks of the
// camera control register bank. Included by the register bank design file and the bench files.
`ifndef CCR_MAP_SVH
`define CCR_MAP_SVH

`define CCR_ADDR_WRITE 8'h42
`define CCR_ADDR_READ 8'h43

`define CCR_OFS_AGC_GAIN_LOW 5'h00
`define CCR_OFS_AWB_BLUE_GAIN 5'h01
`define CCR_OFS_AWB_RED_GAIN 5'h02
`define CCR_OFS_VERTICAL_FRAME_CTRL 5'h03
`define CCR_OFS_FORMAT_EXPOSURE_LOW_CTRL 5'h04
`define CCR_OFS_BLUE_U_AVERAGE_LEVEL 5'h05
`define CCR_OFS_GREEN_Y_AVERAGE_LEVEL 5'h06
`define CCR_OFS_EXPOSURE_TOP_BITS 5'h07
`define CCR_OFS_RED_V_AVERAGE_LEVEL 5'h08
`define CCR_OFS_SLEEP_DRIVE_CTRL 5'h09
`define CCR_OFS_PRODUCT_IDENT_HIGH 5'h0A
`define CCR_OFS_PRODUCT_IDENT_LOW 5'h0B
`define CCR_OFS_OUTPUT_SWAP_TRISTATE_CTRL 5'h0C
`define CCR_OFS_WINDOW_AVERAGE_CTRL 5'h0D
`define CCR_OFS_RESERVED_CTRL_FIVE 5'h0E
`define CCR_OFS_BLACK_LINE_TIMING_CTRL 5'h0F
`define CCR_OFS_EXPOSURE_MID_BITS 5'h10
`define CCR_OFS_LAST 8'h10
`define CCR_NUM_REGS 17

`define CCR_RST_AWB_GAIN 8'h80
`define CCR_RST_SLEEP_DRIVE_CTRL 8'h01
`define CCR_RST_RESERVED_CTRL_FIVE 8'h01
`define CCR_RST_BLACK_LINE_TIMING_CTRL 8'h43
`define CCR_RST_EXPOSURE_MID_BITS 8'h40
`define CCR_RST_ZERO 8'h00

`define CCR_MASK_ALL 8'hFF
`define CCR_MASK_NONE 8'h00
`define CCR_MASK_VERTICAL_FRAME_CTRL 8'hCF
`define CCR_MASK_FORMAT_EXPOSURE_LOW_CTRL 8'h43
`define CCR_MASK_EXPOSURE_TOP_BITS 8'h3F
`define CCR_MASK_SLEEP_DRIVE_CTRL 8'h13
`define CCR_MASK_OUTPUT_SWAP_TRISTATE_CTRL 8'h78
`define CCR_MASK_WINDOW_AVERAGE_CTRL 8'h30
`define CCR_MASK_BLACK_LINE_TIMING_CTRL 8'h82

`define CCR_BIT_CCIR656 6
`define CCR_BIT_SOFT_SLEEP 4
`define CCR_BIT_SWAP 6
`define CCR_BIT_PCLK_KEEP 5
`define CCR_BIT_DATA_KEEP 4
`define CCR_BIT_SCALE 3
`define CCR_BIT_BLACK_LINE_VALID 7
`define CCR_BIT_TIMING_RESET 1

`endif

// ### shared/ccr_pkg.sv
// Types shared by the camera control register bank design files.
// Assumes ccr_map.svh carries the numeric constants.
package ccr_pkg;

  typedef enum logic [8:0] {
    CCR_IDLE      = 9'b000000001,
    CCR_ADDR      = 9'b000000010,
    CCR_ADDR_ACK  = 9'b000000100,
    CCR_SUB       = 9'b000001000,
    CCR_SUB_ACK   = 9'b000010000,
    CCR_WDATA     = 9'b000100000,
    CCR_WDATA_ACK = 9'b001000000,
    CCR_RDATA     = 9'b010000000,
    CCR_RDATA_ACK = 9'b100000000
  } ccr_state_t;

endpackage

// ### rtl/ccr_sync.sv
// Two-flop synchronisers for pins that arrive from outside the clock domain.
// Assumes the caller reads only the second stage.
`timescale 1ns/1ps
module ccr_sync (
  input wire logic clock_in,         // Block clock.
  input wire logic resetn_in,        // Asynchronous reset, active low.
  input wire logic ce_in,            // Clock enable, freezes the stages.
  input wire logic [2:0] async_in,   // Pin levels from outside the domain.
  output logic [2:0] sync_out        // Synchronised levels.
);
  logic [2:0] stage_one;
  // Serial pins idle high and power-down idles low, so reset shows no false event.
  localparam logic [2:0] RST_LVL = 3'b011;

  for (genvar gi = 0; gi < 3; gi++) begin : g_bit
    always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
        stage_one[gi] <= RST_LVL[gi];
        sync_out[gi] <= RST_LVL[gi];
      end else if (ce_in) begin
        stage_one[gi] <= async_in[gi];
        sync_out[gi] <= stage_one[gi];
      end
    end
  end
endmodule

// ### rtl/ccr_bank.sv
// Camera control register bank, offsets 0x00 to 0x10, with its serial slave.
// Assumes the serial clock and data pins and power-down come straight from
// pins; pixel, average and format-change inputs come from this clock domain.
`timescale 1ns/1ps
`include "ccr_map.svh"
module ccr_bank
  import ccr_pkg::*;
#(
  parameter logic [7:0] IDENT_HIGH = 8'hA5, // Arbitrary value.
  parameter logic [7:0] IDENT_LOW = 8'h5A   // Arbitrary value.
) (
  input wire logic clock_in,               // 25 MHz block clock.
  input wire logic resetn_in,              // Asynchronous reset, active low.
  input wire logic ce_in,                  // Clock enable, freezes all state.
  input wire logic serial_clk_in,          // Serial bus clock pin.
  input wire logic serial_data_in,         // Serial bus data pin level.
  output logic serial_data_out,            // Serial data drive value (low).
  output logic serial_data_oe_n_out,       // Serial data enable, low drives.
  input wire logic power_down_in,          // Power-down pin.
  input wire logic avg_valid_in,           // Average levels ready, one cycle.
  input wire logic [7:0] avg_u_b_in,       // U/B average for current format.
  input wire logic [7:0] avg_y_gb_in,      // Y/Gb average for current format.
  input wire logic [7:0] avg_v_r_in,       // V/R average for current format.
  input wire logic format_change_in,       // Output format changed, pulse.
  input wire logic [7:0] pixel_data_in,    // Pixel data from the pipeline.
  input wire logic line_valid_in,          // Line valid from the pipeline.
  input wire logic black_row_in,           // Current row is optical black.
  output logic [7:0] pixel_data_out,       // Pixel data pins.
  output logic pixel_data_oe_n_out,        // Data pin enable, low drives.
  output logic pixel_clk_oe_n_out,         // Pixel clock enable, low drives.
  output logic line_valid_out,             // Line valid pin.
  output logic [9:0] automatic_gain_value_out, // Gain value.
  output logic [15:0] exposure_value_out,  // Exposure value.
  output logic [7:0] white_balance_blue_out, // Blue channel gain.
  output logic [7:0] white_balance_red_out,  // Red channel gain.
  output logic [1:0] vertical_end_low_out,   // End row low bits.
  output logic [1:0] vertical_start_low_out, // Start row low bits.
  output logic embedded_sync_out,          // Embedded-sync output format.
  output logic soft_sleep_out,             // Soft sleep request.
  output logic [1:0] drive_strength_out,   // Drive strength code.
  output logic scale_enable_out,           // Output scaling enable.
  output logic [1:0] average_window_out,   // 0 full, 1 half, 2 or 3 quarter.
  output logic timing_reset_out            // Timing reset, one-cycle pulse.
);
  logic [2:0] pins_sync;
  logic scl_s;
  logic sda_s;
  logic pdown_s;
  logic scl_q;
  logic sda_q;
  ccr_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] txreg;
  logic [7:0] reg_ptr;
  logic sda_low;
  logic is_read;
  logic master_ack;
  logic [7:0] regs [0:`CCR_NUM_REGS-1];

  function automatic logic [7:0] reg_default(input int idx);
    case (idx)
      1, 2: reg_default = `CCR_RST_AWB_GAIN;
      9: reg_default = `CCR_RST_SLEEP_DRIVE_CTRL;
      10: reg_default = IDENT_HIGH;
      11: reg_default = IDENT_LOW;
      14: reg_default = `CCR_RST_RESERVED_CTRL_FIVE;
      15: reg_default = `CCR_RST_BLACK_LINE_TIMING_CTRL;
      16: reg_default = `CCR_RST_EXPOSURE_MID_BITS;
      default: reg_default = `CCR_RST_ZERO;
    endcase
  endfunction

  function automatic logic [7:0] reg_mask(input int idx);
    case (idx)
      3: reg_mask = `CCR_MASK_VERTICAL_FRAME_CTRL;
      4: reg_mask = `CCR_MASK_FORMAT_EXPOSURE_LOW_CTRL;
      7: reg_mask = `CCR_MASK_EXPOSURE_TOP_BITS;
      9: reg_mask = `CCR_MASK_SLEEP_DRIVE_CTRL;
      10, 11, 14: reg_mask = `CCR_MASK_NONE;
      12: reg_mask = `CCR_MASK_OUTPUT_SWAP_TRISTATE_CTRL;
      13: reg_mask = `CCR_MASK_WINDOW_AVERAGE_CTRL;
      15: reg_mask = `CCR_MASK_BLACK_LINE_TIMING_CTRL;
      default: reg_mask = `CCR_MASK_ALL;
    endcase
  endfunction

  ccr_sync u_sync (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .async_in({power_down_in, serial_data_in, serial_clk_in}),
    .sync_out(pins_sync)
  );

  assign scl_s = pins_sync[0];
  assign sda_s = pins_sync[1];
  assign pdown_s = pins_sync[2];

  // Start and stop are data edges while the serial clock stays high.
  wire start_seen = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_seen = scl_s & scl_q & ~sda_q & sda_s;
  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire byte_done = (bit_cnt == 4'h8);
  wire addr_write = (shreg == `CCR_ADDR_WRITE);
  wire addr_read = (shreg == `CCR_ADDR_READ);
  wire in_range = (reg_ptr <= `CCR_OFS_LAST);
  wire [7:0] rd_data = in_range ? regs[reg_ptr[4:0]] : 8'h00;
  wire wr_fire = ce_in & scl_fall & byte_done & (state == CCR_WDATA);
  wire rd_load = ce_in & scl_fall & (((state == CCR_ADDR_ACK) & is_read)
                 | ((state == CCR_RDATA_ACK) & master_ack));
  wire shift_in = scl_rise & ((state == CCR_ADDR) | (state == CCR_SUB)
                  | (state == CCR_WDATA));

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (ce_in) begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= CCR_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      txreg <= 8'h00;
      reg_ptr <= 8'h00;
      sda_low <= 1'b0;
      is_read <= 1'b0;
      master_ack <= 1'b0;
    end else if (ce_in) begin
      if (start_seen) begin
        state <= CCR_ADDR;
        bit_cnt <= 4'h0;
        sda_low <= 1'b0;
      end else if (stop_seen) begin
        state <= CCR_IDLE;
        sda_low <= 1'b0;
      end else if (shift_in) begin
        shreg <= {shreg[6:0], sda_s};
        bit_cnt <= bit_cnt + 4'h1;
      end else if (scl_rise && state == CCR_RDATA_ACK) begin
        master_ack <= ~sda_s;
      end else if (scl_fall) begin
        unique case (state)
          CCR_IDLE: begin
            sda_low <= 1'b0;
          end
          CCR_ADDR: begin
            if (byte_done) begin
              // Any other slave byte leaves the bus untouched.
              sda_low <= addr_write | addr_read;
              is_read <= addr_read;
              state <= (addr_write | addr_read) ? CCR_ADDR_ACK : CCR_IDLE;
            end
          end
          CCR_ADDR_ACK: begin
            bit_cnt <= is_read ? 4'h1 : 4'h0;
            state <= is_read ? CCR_RDATA : CCR_SUB;
            txreg <= rd_data;
            sda_low <= is_read ? ~rd_data[7] : 1'b0;
          end
          CCR_SUB: begin
            if (byte_done) begin
              reg_ptr <= shreg;
              sda_low <= 1'b1;
              state <= CCR_SUB_ACK;
            end
          end
          CCR_SUB_ACK, CCR_WDATA_ACK: begin
            sda_low <= 1'b0;
            bit_cnt <= 4'h0;
            state <= CCR_WDATA;
          end
          CCR_WDATA: begin
            if (byte_done) begin
              reg_ptr <= reg_ptr + 8'h01;
              sda_low <= 1'b1;
              state <= CCR_WDATA_ACK;
            end
          end
          CCR_RDATA: begin
            if (byte_done) begin
              reg_ptr <= reg_ptr + 8'h01;
              sda_low <= 1'b0;
              state <= CCR_RDATA_ACK;
            end else begin
              txreg <= {txreg[6:0], 1'b0};
              sda_low <= ~txreg[6];
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
          CCR_RDATA_ACK: begin
            // A not-acknowledge ends the read; the bus waits for stop.
            bit_cnt <= 4'h1;
            txreg <= rd_data;
            sda_low <= master_ack & ~rd_data[7];
            state <= master_ack ? CCR_RDATA : CCR_IDLE;
          end
        endcase
      end
    end
  end

  // Masked bits keep their reset value, so reserved and identity bits never move.
  for (genvar gi = 0; gi < `CCR_NUM_REGS; gi++) begin : g_reg
    localparam logic [7:0] RST = reg_default(gi);
    localparam logic [7:0] MSK = reg_mask(gi);
    wire is_avg = (gi == 5) || (gi == 6) || (gi == 8);
    wire [7:0] avg_val = (gi == 5) ? avg_u_b_in : ((gi == 6) ? avg_y_gb_in : avg_v_r_in);
    wire host_wr = wr_fire && in_range && (reg_ptr[4:0] == 5'(gi));
    wire [7:0] next_reg = (is_avg && avg_valid_in) ? avg_val
                          : ((shreg & MSK) | (RST & ~MSK));
    always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
        regs[gi] <= RST;
      end else if (ce_in && (host_wr || (is_avg && avg_valid_in))) begin
        regs[gi] <= next_reg;
      end
    end
  end

  wire [7:0] swapped = {pixel_data_in[0], pixel_data_in[1], pixel_data_in[2],
                        pixel_data_in[3], pixel_data_in[4], pixel_data_in[5],
                        pixel_data_in[6], pixel_data_in[7]};
  wire [7:0] r_swap = regs[`CCR_OFS_OUTPUT_SWAP_TRISTATE_CTRL];
  wire [7:0] r_black = regs[`CCR_OFS_BLACK_LINE_TIMING_CTRL];
  wire [7:0] r_vert = regs[`CCR_OFS_VERTICAL_FRAME_CTRL];
  wire [7:0] r_fmt = regs[`CCR_OFS_FORMAT_EXPOSURE_LOW_CTRL];
  wire [7:0] r_sleep = regs[`CCR_OFS_SLEEP_DRIVE_CTRL];

  assign serial_data_out = 1'b0;
  assign serial_data_oe_n_out = ~sda_low;

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pixel_data_out <= 8'h00;
      pixel_data_oe_n_out <= 1'b0;
      pixel_clk_oe_n_out <= 1'b0;
      line_valid_out <= 1'b0;
      timing_reset_out <= 1'b0;
    end else if (ce_in) begin
      pixel_data_out <= r_swap[`CCR_BIT_SWAP] ? swapped : pixel_data_in;
      pixel_data_oe_n_out <= pdown_s & ~r_swap[`CCR_BIT_DATA_KEEP];
      pixel_clk_oe_n_out <= pdown_s & ~r_swap[`CCR_BIT_PCLK_KEEP];
      line_valid_out <= line_valid_in
                        & (~black_row_in | r_black[`CCR_BIT_BLACK_LINE_VALID]);
      timing_reset_out <= format_change_in & r_black[`CCR_BIT_TIMING_RESET];
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      automatic_gain_value_out <= 10'h000;
      exposure_value_out <= 16'h0000;
      white_balance_blue_out <= 8'h00;
      white_balance_red_out <= 8'h00;
      vertical_end_low_out <= 2'h0;
      vertical_start_low_out <= 2'h0;
      embedded_sync_out <= 1'b0;
      soft_sleep_out <= 1'b0;
      drive_strength_out <= 2'h0;
      scale_enable_out <= 1'b0;
      average_window_out <= 2'h0;
    end else if (ce_in) begin
      automatic_gain_value_out <= {r_vert[7:6], regs[`CCR_OFS_AGC_GAIN_LOW]};
      exposure_value_out <= {regs[`CCR_OFS_EXPOSURE_TOP_BITS][5:0],
                             regs[`CCR_OFS_EXPOSURE_MID_BITS], r_fmt[1:0]};
      white_balance_blue_out <= regs[`CCR_OFS_AWB_BLUE_GAIN];
      white_balance_red_out <= regs[`CCR_OFS_AWB_RED_GAIN];
      vertical_end_low_out <= r_vert[3:2];
      vertical_start_low_out <= r_vert[1:0];
      embedded_sync_out <= r_fmt[`CCR_BIT_CCIR656];
      soft_sleep_out <= r_sleep[`CCR_BIT_SOFT_SLEEP];
      drive_strength_out <= r_sleep[1:0];
      scale_enable_out <= r_swap[`CCR_BIT_SCALE];
      average_window_out <= regs[`CCR_OFS_WINDOW_AVERAGE_CTRL][5:4];
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);

  AST_SLAVE_BYTE: assert property ($rose(state == CCR_ADDR_ACK) |->
    ((shreg == `CCR_ADDR_WRITE) || (shreg == `CCR_ADDR_READ)) && sda_low)
    else $error("Acknowledged a foreign slave byte");
  AST_GAIN_VALUE: assert property (ce_in |=> automatic_gain_value_out ==
    {$past(r_vert[7:6]), $past(regs[`CCR_OFS_AGC_GAIN_LOW])})
    else $error("Gain value not built from its two registers");
  AST_EXPOSURE_VALUE: assert property (ce_in |=> exposure_value_out ==
    {$past(regs[`CCR_OFS_EXPOSURE_TOP_BITS][5:0]),
     $past(regs[`CCR_OFS_EXPOSURE_MID_BITS]), $past(r_fmt[1:0])})
    else $error("Exposure value not built from its three registers");
  AST_BLUE_WRITE: assert property (wr_fire && reg_ptr == 8'h01 && !avg_valid_in |=>
    regs[`CCR_OFS_AWB_BLUE_GAIN] == $past(shreg))
    else $error("Blue gain did not take the written byte");
  AST_IDENT_FIXED: assert property (regs[`CCR_OFS_PRODUCT_IDENT_HIGH] == IDENT_HIGH &&
    regs[`CCR_OFS_PRODUCT_IDENT_LOW] == IDENT_LOW)
    else $error("Identity bytes changed");
  AST_RESERVED_HOLD: assert property (regs[`CCR_OFS_RESERVED_CTRL_FIVE] ==
    `CCR_RST_RESERVED_CTRL_FIVE && r_fmt[7] == 1'b0 && r_black[0] == 1'b1)
    else $error("Reserved bits left their reset values");
  AST_AVG_UPDATE: assert property (ce_in && avg_valid_in |=>
    regs[`CCR_OFS_GREEN_Y_AVERAGE_LEVEL] == $past(avg_y_gb_in))
    else $error("Average level not updated by the device");
  AST_CLK_TRISTATE: assert property (ce_in && pdown_s &&
    !r_swap[`CCR_BIT_PCLK_KEEP] |=> pixel_clk_oe_n_out)
    else $error("Pixel clock driven in power-down");
  AST_DATA_TRISTATE: assert property (ce_in && !pdown_s |=> !pixel_data_oe_n_out)
    else $error("Data pins released outside power-down");
  AST_BLACK_LINE: assert property (ce_in && black_row_in &&
    !r_black[`CCR_BIT_BLACK_LINE_VALID] |=> !line_valid_out)
    else $error("Line valid shown on a black row");
  AST_TIMING_RESET: assert property (ce_in && format_change_in &&
    r_black[`CCR_BIT_TIMING_RESET] |=> timing_reset_out ##1
    (!timing_reset_out || $past(format_change_in)))
    else $error("Timing reset missing on format change");
  AST_SLEEP: assert property (ce_in |=>
    soft_sleep_out == $past(r_sleep[`CCR_BIT_SOFT_SLEEP]))
    else $error("Soft sleep does not follow its bit");

  COV_WRITE: cover property (wr_fire);
  COV_READ: cover property (rd_load ##1 state == CCR_RDATA);
  COV_AVG: cover property (ce_in && avg_valid_in);
  COV_POWER_DOWN: cover property (pixel_data_oe_n_out);
endmodule

// ### bench/ccr_host.sv
// Behavioural host controller driving the camera control serial bus.
// Assumes an open-drain data wire with a pull-up and a 320 ns bit period.
`timescale 1ns/1ps
`include "ccr_map.svh"
module ccr_host (
  input wire logic dev_data_in, // Device data drive value.
  input wire logic dev_oe_n_in, // Device data enable, low drives.
  output logic scl_out,         // Serial clock, high while idle.
  output logic sda_out          // Resolved data wire level.
);
  logic drv;
  // A released wire is pulled up, so no stale level lingers on it.
  assign sda_out = drv & (dev_oe_n_in | dev_data_in);
  initial begin
    drv = 1'b1;
    scl_out = 1'b1;
  end
  task automatic start();
    #160 drv = 1'b0;
    #160 scl_out = 1'b0;
  endtask
  task automatic stop();
    #80 drv = 1'b0;
    #120 scl_out = 1'b1;
    #160 drv = 1'b1;
    #160;
  endtask
  // Nine clocks, most significant bit first; bit 0 is the acknowledge slot.
  task automatic unit(input logic [8:0] s, output logic [8:0] g);
    for (int i = 8; i >= 0; i--) begin
      #80 drv = s[i];
      #120 scl_out = 1'b1;
      #80 g[i] = sda_out;
      #40 scl_out = 1'b0;
    end
  endtask
  task automatic wr(input logic [7:0] sa, input logic [7:0] o, input logic [7:0] d,
                    output logic ok);
    logic [8:0] a, b, c;
    start();
    unit({sa, 1'b1}, a);
    unit({o, 1'b1}, b);
    unit({d, 1'b1}, c);
    stop();
    ok = ~(a[0] | b[0] | c[0]);
  endtask
  task automatic rd(input logic [7:0] o, output logic [7:0] d, output logic ok);
    logic [8:0] a, b, c, e;
    start();
    unit({`CCR_ADDR_WRITE, 1'b1}, a);
    unit({o, 1'b1}, b);
    stop();
    start();
    unit({`CCR_ADDR_READ, 1'b1}, c);
    unit(9'h1FF, e);
    stop();
    d = e[8:1];
    ok = ~(a[0] | b[0] | c[0]);
  endtask
  // Two data bytes in one write, so the offset must step between them.
  task automatic wr2(input logic [7:0] o, input logic [7:0] d0, input logic [7:0] d1,
                     output logic ok);
    logic [8:0] a, b, c, e;
    start();
    unit({`CCR_ADDR_WRITE, 1'b1}, a);
    unit({o, 1'b1}, b);
    unit({d0, 1'b1}, c);
    unit({d1, 1'b1}, e);
    stop();
    ok = ~(a[0] | b[0] | c[0] | e[0]);
  endtask
  // The host acknowledges the first byte, so the device sends the next offset too.
  task automatic rd2(input logic [7:0] o, output logic [7:0] d0, output logic [7:0] d1,
                     output logic ok);
    logic [8:0] a, b, c, e, f;
    start();
    unit({`CCR_ADDR_WRITE, 1'b1}, a);
    unit({o, 1'b1}, b);
    stop();
    start();
    unit({`CCR_ADDR_READ, 1'b1}, c);
    unit(9'h1FE, e);
    unit(9'h1FF, f);
    stop();
    d0 = e[8:1];
    d1 = f[8:1];
    ok = ~(a[0] | b[0] | c[0]);
  endtask
endmodule

// ### bench/tb_top.sv
// Self-checking bench for the camera control register bank.
// Assumes the host model owns the serial pins; all other inputs are driven here.
`timescale 1ns/1ps
`include "ccr_map.svh"
module tb_top;
  typedef struct {string n; logic [15:0] e;} ccr_note_t;
  localparam logic [7:0] ID_H = 8'h3C; // Arbitrary value.
  localparam logic [7:0] ID_L = 8'hC3; // Arbitrary value.
  logic clock_in = 1'b0, resetn_in = 1'b0, scl, sda, sdo, sd_oe_n, pd = 1'b0;
  logic avg_v = 1'b0, fmt = 1'b0, lv = 1'b0, blk = 1'b0, ok, ce = 1'b1;
  logic [7:0] b0, b1;
  logic pd_oe, pc_oe, lv_o, es, ss, sc, tr;
  logic [7:0] au = 8'h00, ay = 8'h00, av = 8'h00, pix = 8'h00, rv, pix_o, wbb, wbr;
  logic [9:0] gain;
  logic [15:0] expo, s;
  logic [1:0] ve, vs, ds, aw;
  logic [7:0] sh [17];
  logic [7:0] rst_v [17] = '{8'h00, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h01, ID_H, ID_L, 8'h00, 8'h00, 8'h01, 8'h43, 8'h40};
  logic [7:0] msk [17] = '{8'hFF, 8'hFF, 8'hFF, 8'hCF, 8'h43, 8'hFF, 8'hFF, 8'h3F,
    8'hFF, 8'h13, 8'h00, 8'h00, 8'h78, 8'h30, 8'h00, 8'h82, 8'hFF};
  int n_errors = 0, checks_done = 0, seed = 70465;
  ccr_note_t exp_q[$], t;
  logic [15:0] obs_q[$];
  always #20 clock_in = ~clock_in;
  ccr_host host(.dev_data_in(sdo), .dev_oe_n_in(sd_oe_n), .scl_out(scl), .sda_out(sda));
  ccr_bank #(.IDENT_HIGH(ID_H), .IDENT_LOW(ID_L)) dut(.clock_in(clock_in),
    .resetn_in(resetn_in), .ce_in(ce), .serial_clk_in(scl), .serial_data_in(sda),
    .serial_data_out(sdo), .serial_data_oe_n_out(sd_oe_n), .power_down_in(pd),
    .avg_valid_in(avg_v), .avg_u_b_in(au), .avg_y_gb_in(ay), .avg_v_r_in(av),
    .format_change_in(fmt), .pixel_data_in(pix), .line_valid_in(lv), .black_row_in(blk),
    .pixel_data_out(pix_o), .pixel_data_oe_n_out(pd_oe), .pixel_clk_oe_n_out(pc_oe),
    .line_valid_out(lv_o), .automatic_gain_value_out(gain), .exposure_value_out(expo),
    .white_balance_blue_out(wbb), .white_balance_red_out(wbr), .vertical_end_low_out(ve),
    .vertical_start_low_out(vs), .embedded_sync_out(es), .soft_sleep_out(ss),
    .drive_strength_out(ds), .scale_enable_out(sc), .average_window_out(aw),
    .timing_reset_out(tr));
  task ck(string n, logic [15:0] e, logic [15:0] v);
    exp_q.push_back('{n, e});
    obs_q.push_back(v);
  endtask
  always @(posedge clock_in) begin
    while (obs_q.size() > 0) begin
      t = exp_q.pop_front();
      s = obs_q.pop_front();
      checks_done++;
      if (s !== t.e) begin
        n_errors++;
        $display("BAD %s expected %h seen %h", t.n, t.e, s);
      end
    end
  end
  task wr(logic [7:0] o, logic [7:0] d);
    host.wr(`CCR_ADDR_WRITE, o, d, ok);
    ck("write ack", 16'h1, 16'(ok));
  endtask
  task rdck(logic [7:0] o, logic [7:0] e);
    logic [7:0] d;
    host.rd(o, d, ok);
    ck("read ack", 16'h1, 16'(ok));
    ck($sformatf("reg %h", o), 16'(e), 16'(d));
  endtask
  task summarize();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #2_000_000;
    n_errors++;
    summarize();
  end
  initial begin
    repeat (20) @(posedge clock_in);
    @(negedge clock_in) resetn_in = 1'b1;
    repeat (4) @(negedge clock_in);
    ck("reset blue", 16'h80, 16'(wbb));
    ck("reset drive", 16'h1, 16'(ds));
    ck("reset exposure", 16'h0100, expo);
    for (int o = 0; o < 17; o++) rdck(o[7:0], rst_v[o]);
    $display("test reset values done");
    // The host keeps reserved bits at their defaults.
    for (int o = 0; o < 17; o++) begin
      sh[o] = (8'($random(seed)) & msk[o]) | (rst_v[o] & ~msk[o]);
      wr(o[7:0], sh[o]);
    end
    sh[1] = 8'($random(seed));
    sh[2] = 8'($random(seed));
    host.wr2(8'h01, sh[1], sh[2], ok);
    ck("burst write ack", 16'h1, 16'(ok));
    for (int o = 0; o < 17; o++) rdck(o[7:0], sh[o]);
    host.rd2(8'h01, b0, b1, ok);
    ck("burst read ack", 16'h1, 16'(ok));
    ck("burst first", 16'(sh[1]), 16'(b0));
    ck("burst second", 16'(sh[2]), 16'(b1));
    ck("gain", 16'({sh[3][7:6], sh[0]}), 16'(gain));
    ck("exposure", {sh[7][5:0], sh[16], sh[4][1:0]}, expo);
    ck("end row", 16'(sh[3][3:2]), 16'(ve));
    ck("start row", 16'(sh[3][1:0]), 16'(vs));
    ck("embedded sync", 16'(sh[4][6]), 16'(es));
    ck("scale", 16'(sh[12][3]), 16'(sc));
    ck("red gain", 16'(sh[2]), 16'(wbr));
    $display("test random registers done");
    // Deliberate writes to places that must ignore them.
    foreach (msk[o]) if (msk[o] == 8'h00) begin
      wr(o[7:0], 8'hFF);
      rdck(o[7:0], rst_v[o]);
    end
    wr(8'h11, 8'hFF);
    rdck(8'h11, 8'h00);
    host.wr(8'h44, 8'h00, 8'h12, ok);
    ck("foreign slave ack", 16'h0, 16'(ok));
    rdck(8'h00, sh[0]);
    for (int i = 0; i < 4; i++) begin
      wr(8'h09, {3'b000, i[0], 2'b00, i[1:0]});
      wr(8'h0D, {2'b00, i[1:0], 4'h0});
      ck("drive", 16'(i[1:0]), 16'(ds));
      ck("sleep", 16'(i[0]), 16'(ss));
      ck("window", 16'(i[1:0]), 16'(aw));
    end
    $display("test codes done");
    for (int i = 0; i < 8; i++) begin
      wr(8'h0C, {1'b0, i[2:0], 4'h0});
      wr(8'h0F, {i[0], 5'b10000, i[1], 1'b1});
      @(negedge clock_in);
      {pd, blk, lv, fmt} = 4'hF;
      pix = 8'($random(seed));
      rv = {<<{pix}};
      @(negedge clock_in) fmt = 1'b0;
      ck("timing reset", 16'(i[1]), 16'(tr));
      @(negedge clock_in) ck("timing reset end", 16'h0, 16'(tr));
      repeat (5) @(negedge clock_in);
      ck("pixel", 16'(i[2] ? rv : pix), 16'(pix_o));
      ck("black line valid", 16'(i[0]), 16'(lv_o));
      ck("clock oe_n", 16'(!i[1]), 16'(pc_oe));
      ck("data oe_n", 16'(!i[0]), 16'(pd_oe));
      {pd, blk} = 2'b00;
      repeat (6) @(negedge clock_in);
      ck("awake oe_n", 16'h0, 16'({pc_oe, pd_oe}));
      ck("line valid", 16'h1, 16'(lv_o));
    end
    // A low clock enable holds every flop, so the pixel byte must not move.
    @(negedge clock_in) ce = 1'b0;
    pix = ~pix;
    repeat (3) @(negedge clock_in);
    ck("frozen pixel", 16'(rv), 16'(pix_o));
    rv = {<<{pix}};
    ce = 1'b1;
    @(negedge clock_in) ck("thawed pixel", 16'(rv), 16'(pix_o));
    $display("test pixel path done");
    @(negedge clock_in);
    {au, ay, av} = 24'($random(seed));
    avg_v = 1'b1;
    @(negedge clock_in) avg_v = 1'b0;
    rdck(8'h05, au);
    rdck(8'h06, ay);
    rdck(8'h08, av);
    $display("test averages done");
    repeat (3) @(negedge clock_in);
    summarize();
  end
endmodule
